// File: include/otg_role_consts.vh
// Constants for the dual-role OTG role controller: map, fields, timing
`ifndef OTG_ROLE_CONSTS_VH
`define OTG_ROLE_CONSTS_VH

// Register byte offsets
`define REG_CTRL       8'h00
`define REG_STATE      8'h04
`define REG_PINS       8'h08

// Control register fields
`define CTRL_WANT_BUS  0
`define CTRL_APP_DONE  1
`define CTRL_HNP_EN    2
`define CTRL_BCON_NOTO 3
`define CTRL_RELEASE   4
`define CTRL_W         5
`define CTRL_RESET     5'h00

// Synchronised input bit positions
`define IN_ID_B        0
`define IN_VBUS_VLD    1
`define IN_A_SESS      2
`define IN_B_SESS      3
`define IN_B_SEND      4
`define IN_CONN        5
`define IN_IDLE        6
`define IN_RESUME      7
`define IN_DLINE       8
`define IN_W           9

// Time base
`define CLK_NS         4
`define TICK_NS        125000
`define TICK_CYC       (`TICK_NS / `CLK_NS)

// Times in microseconds, counts in ticks
`define T_VRISE_US     100000
`define N_VRISE        (`T_VRISE_US * 1000 / `TICK_NS)
`define T_BCON_US      200000
`define N_BCON         (`T_BCON_US * 1000 / `TICK_NS)
`define T_SUSP_US      150000
`define N_SUSP         (`T_SUSP_US * 1000 / `TICK_NS)
`define T_IDLE_MIN_US  3000
`define N_IDLE_MIN     (`T_IDLE_MIN_US * 1000 / `TICK_NS)
`define T_IDLE_MAX_US  200000
`define N_IDLE_MAX     (`T_IDLE_MAX_US * 1000 / `TICK_NS)
`define T_BIDLE_US     2000
`define N_BIDLE        (`T_BIDLE_US * 1000 / `TICK_NS)
`define T_DP_US        8000
`define N_DP           (`T_DP_US * 1000 / `TICK_NS)
`define T_CHRG_US      30000
`define N_CHRG         (`T_CHRG_US * 1000 / `TICK_NS)
`define T_SRP_US       50000
`define N_SRP          (`T_SRP_US * 1000 / `TICK_NS)
`define T_PLS_MIN_US   5000
`define N_PLS_MIN      (`T_PLS_MIN_US * 1000 / `TICK_NS)
`define T_PLS_MAX_US   10000
`define N_PLS_MAX      (`T_PLS_MAX_US * 1000 / `TICK_NS)
`define T_ACON_US      3125
`define N_ACON         (`T_ACON_US * 1000 / `TICK_NS)

`endif

// File: hw/pin_sync.v
// Three-stage pin synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps
module pin_sync #(
  parameter W = 9
) (
  clk_sys,
  sys_rst,
  pin_in,
  level_out
);
  input  wire         clk_sys;   // System clock
  input  wire         sys_rst;   // Synchronous reset, active high
  input  wire [W-1:0] pin_in;    // Raw asynchronous levels
  output wire [W-1:0] level_out; // Filtered, synchronous levels

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : lane
      reg s1_q; // First stage, read only by the second
      reg s2_q; // Second stage
      reg s3_q; // Third stage
      reg lv_q; // Accepted level
      // Level moves only once stages two and three agree, which masks
      // a single metastable resolution at the cost of one cycle
      always @(posedge clk_sys) begin
        if (sys_rst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          lv_q <= 1'b0;
        end else begin
          s1_q <= pin_in[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lv_q <= s3_q;
          end
        end
      end
      assign level_out[g] = lv_q;
    end
  endgenerate
endmodule

// File: hw/otg_role_ctrl.v
// Dual-role OTG role controller with APB register access
`timescale 1ns/1ps
`include "otg_role_consts.vh"
module otg_role_ctrl #(
  parameter TICK_CYC = `TICK_CYC // Clock cycles per 125 us tick
) (
  clk_sys,
  sys_rst,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  id_pin,
  bus_power_valid_flag,
  host_side_session_valid,
  periph_side_session_valid,
  periph_side_session_ended,
  peer_connected,
  bus_idle,
  bus_resume,
  data_line_high,
  bus_power_drive,
  dplus_pullup_on,
  bus_power_charge,
  host_mode_on
);
  input  wire        clk_sys;                   // System clock
  input  wire        sys_rst;                   // Synchronous reset
  input  wire        psel;                      // APB select
  input  wire        penable;                   // APB access phase
  input  wire        pwrite;                    // APB direction
  input  wire [7:0]  paddr;                     // APB byte address
  input  wire [31:0] pwdata;                    // APB write data
  output wire [31:0] prdata;                    // APB read data
  output wire        pready;                    // APB ready
  output wire        pslverr;                   // APB error
  input  wire        id_pin;                    // High: B cable/none
  input  wire        bus_power_valid_flag;      // Supply valid (A)
  input  wire        host_side_session_valid;   // A session level
  input  wire        periph_side_session_valid; // B session level
  input  wire        periph_side_session_ended; // B session ended
  input  wire        peer_connected;            // Peer pull-up seen
  input  wire        bus_idle;                  // Bus in idle state
  input  wire        bus_resume;                // Resume signalling
  input  wire        data_line_high;            // Data line raised
  output wire        bus_power_drive;           // Drive bus supply
  output wire        dplus_pullup_on;           // D+ pull-up
  output wire        bus_power_charge;          // Supply charge pulse
  output wire        host_mode_on;              // Host mode enable

  // One-hot role states
  localparam [11:0] ST_A_IDLE  = 12'h001;
  localparam [11:0] ST_A_VRISE = 12'h002;
  localparam [11:0] ST_A_BCON  = 12'h004;
  localparam [11:0] ST_A_HOST  = 12'h008;
  localparam [11:0] ST_A_SUSP  = 12'h010;
  localparam [11:0] ST_A_PERI  = 12'h020;
  localparam [11:0] ST_A_VFALL = 12'h040;
  localparam [11:0] ST_B_IDLE  = 12'h080;
  localparam [11:0] ST_B_SRP   = 12'h100;
  localparam [11:0] ST_B_PERI  = 12'h200;
  localparam [11:0] ST_B_ACON  = 12'h400;
  localparam [11:0] ST_B_HOST  = 12'h800;

  // Host mode states: decode used for the output and status
  function host_dec;
    input [11:0] st;
    begin
      host_dec = |(st & (ST_A_BCON | ST_A_HOST | ST_A_SUSP | ST_B_HOST));
    end
  endfunction

  // Bus supply states
  function vbus_dec;
    input [11:0] st;
    begin
      vbus_dec = |(st & (ST_A_VRISE | ST_A_BCON | ST_A_HOST | ST_A_SUSP
                         | ST_A_PERI));
    end
  endfunction

  wire [`IN_W-1:0]   lv;        // Filtered input levels
  reg  [`IN_W-1:0]   lv_q;      // Levels one cycle ago
  reg  [11:0]        state_q;   // Role state
  reg  [11:0]        state_d;
  reg  [14:0]        pre_q;     // Tick prescaler
  reg                tick_q;    // One-cycle tick
  reg  [11:0]        tmr_q;     // Time in state, ticks
  reg  [11:0]        idl_q;     // Time bus idle, ticks
  reg  [11:0]        pls_q;     // Data-line pulse length
  reg  [`CTRL_W-1:0] ctrl_q;    // Software control bits
  reg  [31:0]        prdata_q;  // Read data register
  reg                vbus_q;    // Registered outputs
  reg                dp_q;
  reg                chrg_q;
  reg                host_q;

  // Raw pins cross into the clock domain here; ID enters inverted so that a
  // lane's reset level of 0 means the B role and no false ID change follows reset
  pin_sync #(.W(`IN_W)) u_sync (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .pin_in    ({data_line_high, bus_resume, bus_idle, peer_connected,
                 periph_side_session_ended, periph_side_session_valid,
                 host_side_session_valid, bus_power_valid_flag, ~id_pin}),
    .level_out (lv)
  );

  // Level names and change events
  wire id_b   = ~lv[`IN_ID_B];
  wire id_ev  = lv[`IN_ID_B] ^ lv_q[`IN_ID_B];
  wire vbv    = lv[`IN_VBUS_VLD];
  wire vbv_fl = ~lv[`IN_VBUS_VLD] & lv_q[`IN_VBUS_VLD];
  wire asv    = lv[`IN_A_SESS];
  wire asv_rs = lv[`IN_A_SESS] & ~lv_q[`IN_A_SESS];
  wire bsv    = lv[`IN_B_SESS];
  wire bse    = lv[`IN_B_SEND];
  wire con    = lv[`IN_CONN];
  wire att    = lv[`IN_CONN] & ~lv_q[`IN_CONN];
  wire dis    = ~lv[`IN_CONN] & lv_q[`IN_CONN];
  wire res_ev = lv[`IN_RESUME] & ~lv_q[`IN_RESUME];
  wire dl_fl  = ~lv[`IN_DLINE] & lv_q[`IN_DLINE];
  // Peer SRP: data line pulse of 5 to 10 ms
  wire srp_seen = dl_fl & (pls_q >= `N_PLS_MIN) & (pls_q <= `N_PLS_MAX);

  wire want    = ctrl_q[`CTRL_WANT_BUS];
  wire done    = ctrl_q[`CTRL_APP_DONE];
  wire hnp     = ctrl_q[`CTRL_HNP_EN];
  wire noto    = ctrl_q[`CTRL_BCON_NOTO];
  wire let_go  = ctrl_q[`CTRL_RELEASE];
  // Suspend is read as at least 3 ms of idle
  wire susp    = idl_q >= `N_IDLE_MIN;

  // Event history for edge detection
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      lv_q <= {`IN_W{1'b0}};
    end else begin
      lv_q <= lv;
    end
  end

  // Tick generator and timers; state timer restarts on entry
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pre_q  <= 15'h0000;
      tick_q <= 1'b0;
      tmr_q  <= 12'h000;
      idl_q  <= 12'h000;
      pls_q  <= 12'h000;
    end else begin
      tick_q <= (pre_q == TICK_CYC[14:0] - 15'h0001);
      if (pre_q == TICK_CYC[14:0] - 15'h0001) begin
        pre_q <= 15'h0000;
      end else begin
        pre_q <= pre_q + 15'h0001;
      end
      if (state_d != state_q) begin
        tmr_q <= 12'h000;
      end else if (tick_q && tmr_q != 12'hfff) begin
        tmr_q <= tmr_q + 12'h001;
      end
      // Saturating counters hold their value instead of wrapping
      if (!lv[`IN_IDLE]) begin
        idl_q <= 12'h000;
      end else if (tick_q && idl_q != 12'hfff) begin
        idl_q <= idl_q + 12'h001;
      end
      if (!lv[`IN_DLINE]) begin
        pls_q <= 12'h000;
      end else if (tick_q && pls_q != 12'hfff) begin
        pls_q <= pls_q + 12'h001;
      end
    end
  end

  // Next role state; ID change always takes precedence
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_A_IDLE: begin
        if (id_b) begin
          state_d = ST_B_IDLE;
        end else if (want | asv_rs | att | srp_seen) begin
          state_d = ST_A_VRISE;
        end
      end
      ST_A_VRISE: begin
        if (id_ev) begin
          state_d = ST_A_VFALL;
        end else if (vbv) begin
          state_d = ST_A_BCON;
        end else if (tmr_q >= `N_VRISE) begin
          state_d = ST_A_VFALL;
        end
      end
      ST_A_BCON: begin
        if (id_ev) begin
          state_d = ST_A_VFALL;
        end else if (vbv & con) begin
          state_d = ST_A_HOST;
        end else if (!noto && tmr_q >= `N_BCON) begin
          state_d = ST_A_VFALL;
        end
      end
      ST_A_HOST: begin
        if (id_ev) begin
          state_d = ST_A_BCON;
        end else if (~vbv | done | dis) begin
          state_d = ST_A_VFALL;
        end else if (let_go) begin
          state_d = ST_A_SUSP;
        end
      end
      ST_A_SUSP: begin
        if (id_ev | ~vbv) begin
          state_d = ST_A_VFALL;
        end else if (hnp & dis & (tmr_q < `N_SUSP)) begin
          state_d = ST_A_PERI;
        end else if (tmr_q >= `N_SUSP) begin
          state_d = ST_A_VFALL;
        end else if (want & ~let_go) begin
          state_d = ST_A_HOST;
        end
      end
      ST_A_PERI: begin
        if (id_ev | vbv_fl) begin
          state_d = ST_A_VFALL;
        end else if (idl_q >= `N_IDLE_MIN && idl_q <= `N_IDLE_MAX) begin
          state_d = ST_A_BCON;
        end
      end
      ST_A_VFALL: begin
        if (id_ev | (~asv & ~con)) begin
          state_d = ST_A_IDLE;
        end
      end
      ST_B_IDLE: begin
        if (!id_b) begin
          state_d = ST_A_IDLE;
        end else if (bsv) begin
          state_d = ST_B_PERI;
        end else if (want && idl_q >= `N_BIDLE && bse) begin
          state_d = ST_B_SRP;
        end
      end
      ST_B_SRP: begin
        // Done well inside the 100 ms limit
        if (id_ev || tmr_q >= `N_SRP) begin
          state_d = ST_B_IDLE;
        end
      end
      ST_B_PERI: begin
        if (id_ev | ~bsv) begin
          state_d = ST_B_IDLE;
        end else if (hnp & susp & want) begin
          state_d = ST_B_ACON;
        end
      end
      ST_B_ACON: begin
        if (id_ev | ~bsv) begin
          state_d = ST_B_IDLE;
        end else if (att) begin
          state_d = ST_B_HOST;
        end else if (res_ev || tmr_q >= `N_ACON) begin
          state_d = ST_B_PERI;
        end
      end
      ST_B_HOST: begin
        if (id_ev | ~bsv) begin
          state_d = ST_B_IDLE;
        end else if (done | dis) begin
          state_d = ST_B_PERI;
        end
      end
      default: begin
        // Illegal code recovers into the idle of the B role
        state_d = ST_B_IDLE;
      end
    endcase
  end

  // State and registered pin drives
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= ST_B_IDLE;
      vbus_q  <= 1'b0;
      dp_q    <= 1'b0;
      chrg_q  <= 1'b0;
      host_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      vbus_q  <= vbus_dec(state_q);
      host_q  <= host_dec(state_q);
      // Pull-up is masked whenever host mode is decoded
      dp_q    <= ~host_dec(state_q) &
                 ((state_q == ST_B_PERI) | (state_q == ST_A_PERI) |
                  ((state_q == ST_B_SRP) & (tmr_q < `N_DP)));
      chrg_q  <= (state_q == ST_B_SRP) & (tmr_q < `N_CHRG);
    end
  end

  assign bus_power_drive  = vbus_q;
  assign dplus_pullup_on  = dp_q;
  assign bus_power_charge = chrg_q;
  assign host_mode_on     = host_q;

  // APB decode
  wire hit  = (paddr == `REG_CTRL) | (paddr == `REG_STATE) |
              (paddr == `REG_PINS);
  wire wr   = psel & penable & pwrite & (paddr == `REG_CTRL);

  // Control register; software owns every bit
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr) begin
      ctrl_q <= pwdata[`CTRL_W-1:0];
    end
  end

  // Read data captured in the setup cycle, so it comes from a flop
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata_q <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `REG_CTRL:  prdata_q <= {27'h0000000, ctrl_q};
        `REG_STATE: prdata_q <= {20'h00000, state_q};
        `REG_PINS:  prdata_q <= {19'h00000, host_q, chrg_q, dp_q, vbus_q,
                                 lv[`IN_W-1:1], ~lv[`IN_ID_B]};
        default:    prdata_q <= 32'h00000000;
      endcase
    end
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_q;
endmodule

// File: test/otg_role_ctrl_sva.sv
// Port checker for the OTG role controller
`timescale 1ns/1ps
`include "otg_role_consts.vh"
module otg_role_ctrl_sva #(
  parameter TICK_CYC = 4
) (
  input wire        clk_sys,
  input wire        sys_rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire        id_pin,
  input wire        bus_power_drive,
  input wire        dplus_pullup_on,
  input wire        bus_power_charge,
  input wire        host_mode_on
);
  localparam int PMIN = `N_PLS_MIN * TICK_CYC;             // Shortest pull-up pulse
  localparam int PMAX = `N_PLS_MAX * TICK_CYC;             // Longest pull-up pulse
  localparam int SMAX = (100000000 / `TICK_NS) * TICK_CYC; // Session request bound
  wire       rd_setup = psel & ~penable & ~pwrite;         // Read setup cycle
  reg [31:0] dp_cnt_q;                                     // Cycles pull-up high
  reg [31:0] ch_cnt_q;                                     // Cycles charge high
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Pulse length counters; cleared when the output drops
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      dp_cnt_q <= 0;
      ch_cnt_q <= 0;
    end else begin
      dp_cnt_q <= dplus_pullup_on ? dp_cnt_q + 1 : 0;
      ch_cnt_q <= bus_power_charge ? ch_cnt_q + 1 : 0;
    end
  end
  AST_EXCL: assert property (!(host_mode_on && dplus_pullup_on))
    else $error("host mode and pull-up together");
  AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  AST_RDATA_HOLD: assert property (!$past(rd_setup) |-> $stable(prdata))
    else $error("read data moved without a read setup");
  AST_DRV_A: assert property ($rose(bus_power_drive) |-> !$past(id_pin, 6))
    else $error("supply driven in the B role");
  // The A end acting as peripheral keeps the supply up, so only unpowered rises count
  AST_PU_B: assert property ($rose(dplus_pullup_on) && !bus_power_drive
    |-> $past(id_pin, 6))
    else $error("unpowered pull-up raised in the A role");
  AST_CHG_PU: assert property ($rose(bus_power_charge) |-> ##[0:1] dplus_pullup_on)
    else $error("charge pulse without pull-up pulse");
  AST_CHG_B: assert property (bus_power_charge |-> !bus_power_drive && !host_mode_on)
    else $error("charge pulse outside session request");
  AST_DP_PULSE: assert property ($fell(dplus_pullup_on) && bus_power_charge
    |-> dp_cnt_q >= PMIN && dp_cnt_q <= PMAX)
    else $error("pull-up pulse length out of range");
  AST_SRP_LEN: assert property (ch_cnt_q <= SMAX)
    else $error("session request too long");
  AST_HOST_DRV: assert property ($rose(host_mode_on) && !id_pin |-> bus_power_drive)
    else $error("A host mode without supply");
  // Main scenarios reached
  cover property ($rose(host_mode_on));
  cover property ($rose(bus_power_charge));
  cover property ($rose(bus_power_drive));
  cover property (pslverr);
endmodule
bind otg_role_ctrl otg_role_ctrl_sva #(.TICK_CYC(TICK_CYC)) i_sva (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pslverr(pslverr), .id_pin(id_pin),
  .bus_power_drive(bus_power_drive), .dplus_pullup_on(dplus_pullup_on),
  .bus_power_charge(bus_power_charge), .host_mode_on(host_mode_on));

// File: test/usb_peer_model.sv
// Behavioural peer unit on the far end of the cable
`timescale 1ns/1ps
module usb_peer_model (
  input  wire clk_sys,
  input  wire bus_power_drive,
  input  wire dplus_pullup_on,
  input  wire supply_ok,
  input  wire peer_powers,
  input  wire attach,
  output wire bus_power_valid_flag,
  output wire host_side_session_valid,
  output wire periph_side_session_valid,
  output wire periph_side_session_ended,
  output wire peer_connected,
  output wire data_line_high
);
  reg [7:0] vb_q = 8'h00; // Supply settling line; a real supply is never instant
  // Supply is valid when we drive it and the load is fine, or the peer powers it
  always @(posedge clk_sys) begin
    vb_q <= {vb_q[6:0], (bus_power_drive & supply_ok) | peer_powers};
  end
  assign bus_power_valid_flag      = vb_q[7];
  assign host_side_session_valid   = vb_q[7];
  assign periph_side_session_valid = vb_q[7];
  assign periph_side_session_ended = ~vb_q[7];
  assign peer_connected            = attach;
  assign data_line_high            = dplus_pullup_on; // Line follows our pull-up
endmodule

// File: test/otg_role_ctrl_test.sv
// Self-checking bench for the OTG role controller
`timescale 1ns/1ps
`include "otg_role_consts.vh"
module otg_role_ctrl_test;
  localparam TK = 4;           // Shortened tick keeps the run brief
  reg        clk_sys = 1'b0;   // System clock
  reg        sys_rst = 1'b1;   // Reset
  reg        psel = 1'b0;      // APB select
  reg        penable = 1'b0;   // APB access
  reg        pwrite = 1'b0;    // APB direction
  reg [7:0]  paddr = 8'h00;    // APB address
  reg [31:0] pwdata = 32'h0;   // APB write data
  reg        id_pin = 1'b1;    // Cable type
  reg        supply_ok = 1'b1; // Peer load within budget
  reg        peer_powers = 1'b0; // Peer supplies the bus
  reg        attach = 1'b0;    // Peer pull-up present
  reg        bus_idle = 1'b0;  // Bus idle
  reg        bus_resume = 1'b0; // Resume signalling
  wire [31:0] prdata;
  wire        pready, pslverr, vbv, hsv, psv, pse, pcn, dlh;
  wire        bus_power_drive, dplus_pullup_on, bus_power_charge, host_mode_on;
  integer     failures, n_tests, cyc, t0;
  reg [31:0]  rd, r;
  reg         err;
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  otg_role_ctrl #(.TICK_CYC(TK)) i_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .id_pin(id_pin),
    .bus_power_valid_flag(vbv), .host_side_session_valid(hsv),
    .periph_side_session_valid(psv), .periph_side_session_ended(pse),
    .peer_connected(pcn), .bus_idle(bus_idle), .bus_resume(bus_resume),
    .data_line_high(dlh), .bus_power_drive(bus_power_drive),
    .dplus_pullup_on(dplus_pullup_on), .bus_power_charge(bus_power_charge),
    .host_mode_on(host_mode_on));
  usb_peer_model i_peer (
    .clk_sys(clk_sys), .bus_power_drive(bus_power_drive),
    .dplus_pullup_on(dplus_pullup_on), .supply_ok(supply_ok),
    .peer_powers(peer_powers), .attach(attach), .bus_power_valid_flag(vbv),
    .host_side_session_valid(hsv), .periph_side_session_valid(psv),
    .periph_side_session_ended(pse), .peer_connected(pcn), .data_line_high(dlh));
  // Microseconds to clock cycles at the shortened tick
  function integer us_cyc(input integer us);
    us_cyc = us * 1000 / `TICK_NS * TK;
  endfunction
  // Compare and count
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task apb(input wr, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) begin
        @(posedge clk_sys);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Poll the state register for a bounded number of reads, then compare
  task wait_st(input [11:0] e, input integer lim);
    integer k;
    begin
      k = 0;
      apb(1'b0, `REG_STATE, 32'h0);
      while (rd !== {20'h0, e} && k < lim) begin
        apb(1'b0, `REG_STATE, 32'h0);
        k = k + 1;
      end
      chk(rd, {20'h0, e});
    end
  endtask
  // Verdict; also reached from the watchdog
  task results;
    begin
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Watchdog sized well above the longest sequence
  initial begin
    repeat (60000) @(posedge clk_sys);
    failures = failures + 1;
    results;
  end
  // Main sequence
  initial begin
    failures = 0;
    n_tests = 0;
    cyc = 0;
    r = $urandom(89874);
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    apb(1'b0, `REG_STATE, 32'h0);
    chk(rd, 32'h080);
    apb(1'b0, `REG_PINS, 32'h0);
    chk(rd, 32'h011);
    r = $urandom;
    apb(1'b1, `REG_CTRL, {r[31:5], 5'h1e});
    apb(1'b0, `REG_CTRL, 32'h0);
    chk(rd, 32'h01e);
    apb(1'b1, `REG_CTRL, 32'h0);
    apb(1'b0, 8'h0c + 8'h04 * ($urandom % 61), 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test registers done");
    bus_idle <= 1'b1; // Session request from B idle
    apb(1'b1, `REG_CTRL, 32'h1);
    wait_st(12'h100, 60);
    chk({bus_power_charge, dplus_pullup_on}, 32'h3);
    t0 = cyc;
    apb(1'b1, `REG_CTRL, 32'h0);
    wait_st(12'h080, 1500);
    chk(cyc - t0 <= us_cyc(100000), 1);
    $display("test session request done");
    repeat ($urandom_range(2, 20)) @(posedge clk_sys);
    peer_powers <= 1'b1; // Peer powers the bus, then role swap
    wait_st(12'h200, 20);
    chk(dplus_pullup_on, 1);
    apb(1'b1, `REG_CTRL, 32'h5);
    wait_st(12'h400, 60);
    attach <= 1'b1;
    chk(dplus_pullup_on, 0);
    wait_st(12'h800, 20);
    chk(host_mode_on, 1);
    apb(1'b1, `REG_CTRL, 32'h0);
    attach <= 1'b0;
    wait_st(12'h200, 20);
    apb(1'b1, `REG_CTRL, 32'h5);
    wait_st(12'h400, 60);
    bus_idle <= 1'b0;
    wait_st(12'h200, 60);
    apb(1'b1, `REG_CTRL, 32'h0);
    peer_powers <= 1'b0;
    wait_st(12'h080, 20);
    $display("test B role done");
    id_pin <= 1'b0; // A role: full host session
    wait_st(12'h001, 20);
    apb(1'b1, `REG_CTRL, 32'h1);
    wait_st(12'h002, 20);
    chk(bus_power_drive, 1);
    apb(1'b1, `REG_CTRL, 32'h0);
    wait_st(12'h004, 20);
    attach <= 1'b1;
    wait_st(12'h008, 20);
    chk(host_mode_on, 1);
    apb(1'b1, `REG_CTRL, 32'h2);
    wait_st(12'h040, 10);
    chk({bus_power_drive, host_mode_on}, 0);
    attach <= 1'b0;
    apb(1'b1, `REG_CTRL, 32'h0);
    wait_st(12'h001, 30);
    $display("test A session done");
    apb(1'b1, `REG_CTRL, 32'h1); // A hands the bus over, then takes it back
    wait_st(12'h004, 20);
    attach <= 1'b1;
    wait_st(12'h008, 20);
    apb(1'b1, `REG_CTRL, 32'h15);
    wait_st(12'h010, 20);
    attach <= 1'b0;
    wait_st(12'h020, 20);
    chk({host_mode_on, dplus_pullup_on, bus_power_drive}, 32'h3);
    bus_idle <= 1'b1;
    wait_st(12'h004, 60);
    chk(host_mode_on, 1);
    apb(1'b1, `REG_CTRL, 32'h0);
    t0 = cyc;
    wait_st(12'h001, 2500);
    chk(cyc - t0 >= us_cyc(200000) - 20, 1);
    chk(bus_power_drive, 0);
    $display("test role hand-over done");
    supply_ok <= 1'b0; // Supply never becomes valid
    apb(1'b1, `REG_CTRL, 32'h1);
    wait_st(12'h002, 20);
    t0 = cyc;
    apb(1'b1, `REG_CTRL, 32'h0);
    wait_st(12'h001, 1500);
    chk(cyc - t0 >= us_cyc(100000) - 20, 1);
    chk(bus_power_drive, 0);
    $display("test supply timeout done");
    id_pin <= 1'b1;
    wait_st(12'h080, 20);
    $display("test cable change done");
    results;
  end
endmodule
